/* File: design/jtag_tap_defines.vh */
`ifndef JTAG_TAP_DEFINES_VH
`define JTAG_TAP_DEFINES_VH
`define IR_WIDTH            4
`define OP_EXTEST           4'h0
`define OP_SAMPLE           4'h1
`define OP_IDCODE           4'h2
`define OP_USERCODE         4'h3
`define OP_CFG_LOAD         4'h4
`define OP_CFG_START        4'h5
`define OP_ANALYSER         4'h6
`define OP_BYPASS           4'hF
`define IR_CAPTURE          4'h1
`define ST_RESET            4'h0
`define ST_IDLE             4'h1
`define ST_SEL_DR           4'h2
`define ST_CAP_DR           4'h3
`define ST_SH_DR            4'h4
`define ST_EX1_DR           4'h5
`define ST_PAU_DR           4'h6
`define ST_EX2_DR           4'h7
`define ST_UPD_DR           4'h8
`define ST_SEL_IR           4'h9
`define ST_CAP_IR           4'hA
`define ST_SH_IR            4'hB
`define ST_EX1_IR           4'hC
`define ST_PAU_IR           4'hD
`define ST_EX2_IR           4'hE
`define ST_UPD_IR           4'hF
`define ID_RESET            32'h1234_5001
`define USER_RESET          32'h0000_0000
`endif

/* File: design/boundary_scan_test_port.v */
// Summary of operation
// R1 - A standard test access port state machine drives the instruction and data registers.
// R2 - Boundary-scan instructions are refused while configuration is in progress.
// R3 - Bypass puts a one-bit register between the serial input and output.
// R4 - User-code puts a 32-bit user code register in the serial path.
// R5 - Identification puts the identification register in the serial path.
// R6 - Sample/preload captures pin values and loads a pattern without driving pins.
// R7 - External test drives the loaded pattern out and captures the input pins.
// R8 - Configuration load streams serial data out to the configuration logic; configuration start pulses cfg_start at Update-DR.
// R9 - An analyser instruction shifts a probe register; the analyser may also use sample.
// R10 - A 4-bit instruction register is used and unknown codes select bypass.
`timescale 1ns/1ps
`include "jtag_tap_defines.vh"
module boundary_scan_test_port #(
    parameter NPINS   = 8,
    parameter PROBE_W = 16
) (
    input  wire               clk,
    input  wire               srst,
    input  wire               tck,
    input  wire               tms,
    input  wire               tdi,
    input  wire               trst_n,
    input  wire               config_busy,
    input  wire [31:0]        user_code,
    input  wire [NPINS-1:0]   pin_in,
    input  wire [NPINS-1:0]   core_out,
    input  wire [PROBE_W-1:0] probe_in,
    output reg                tdo,
    output reg                tdo_oe,
    output reg  [NPINS-1:0]   pin_out,
    output reg                test_mode,
    output reg                cfg_data,
    output reg                cfg_strobe,
    output reg                cfg_start
);
    reg [2:0]             tck_sync_reg;
    reg [1:0]             tms_sync_reg;
    reg [1:0]             tdi_sync_reg;
    reg [1:0]             trst_sync_reg;
    reg [NPINS-1:0]       pin_sync1_reg;
    reg [NPINS-1:0]       pin_sync2_reg;
    reg [3:0]             state_reg;
    reg [3:0]             state_next;
    reg [3:0]             ir_shift_reg;
    reg [3:0]             ir_reg;
    reg                   bypass_reg;
    reg [31:0]            dr32_reg;
    reg [NPINS-1:0]       bsr_shift_reg;
    reg [NPINS-1:0]       bsr_update_reg;
    reg [PROBE_W-1:0]     probe_reg;
    wire                  tck_rise;
    wire                  tck_fall;
    wire                  tms_s;
    wire                  tdi_s;
    wire [3:0]            op;
    wire                  shift_dr;
    wire                  shift_ir;

    // Edges found from the sampled link clock; 32 ns tck gives 8 clk cycles
    assign tck_rise = tck_sync_reg[1] & ~tck_sync_reg[2];
    assign tck_fall = ~tck_sync_reg[1] & tck_sync_reg[2];
    assign tms_s    = tms_sync_reg[1];
    assign tdi_s    = tdi_sync_reg[1];
    assign shift_dr = (state_reg == `ST_SH_DR);
    assign shift_ir = (state_reg == `ST_SH_IR);

    // Decode with blocking of test instructions during configuration
    function [3:0] decode_op;
        input [3:0] code;
        input       busy;
        begin
            case (code)
                `OP_EXTEST, `OP_SAMPLE:
                    decode_op = busy ? `OP_BYPASS : code; // see R2
                `OP_IDCODE, `OP_USERCODE, `OP_CFG_LOAD, `OP_CFG_START, `OP_ANALYSER:
                    decode_op = code;
                default:
                    decode_op = `OP_BYPASS; // see R10
            endcase
        end
    endfunction

    assign op = decode_op(ir_reg, config_busy);

    always @*
    begin
        state_next = state_reg;
        case (state_reg) // see R1
            `ST_RESET:  state_next = tms_s ? `ST_RESET : `ST_IDLE;
            `ST_IDLE:   state_next = tms_s ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_DR: state_next = tms_s ? `ST_SEL_IR : `ST_CAP_DR;
            `ST_CAP_DR: state_next = tms_s ? `ST_EX1_DR : `ST_SH_DR;
            `ST_SH_DR:  state_next = tms_s ? `ST_EX1_DR : `ST_SH_DR;
            `ST_EX1_DR: state_next = tms_s ? `ST_UPD_DR : `ST_PAU_DR;
            `ST_PAU_DR: state_next = tms_s ? `ST_EX2_DR : `ST_PAU_DR;
            `ST_EX2_DR: state_next = tms_s ? `ST_UPD_DR : `ST_SH_DR;
            `ST_UPD_DR: state_next = tms_s ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_IR: state_next = tms_s ? `ST_RESET : `ST_CAP_IR;
            `ST_CAP_IR: state_next = tms_s ? `ST_EX1_IR : `ST_SH_IR;
            `ST_SH_IR:  state_next = tms_s ? `ST_EX1_IR : `ST_SH_IR;
            `ST_EX1_IR: state_next = tms_s ? `ST_UPD_IR : `ST_PAU_IR;
            `ST_PAU_IR: state_next = tms_s ? `ST_EX2_IR : `ST_PAU_IR;
            `ST_EX2_IR: state_next = tms_s ? `ST_UPD_IR : `ST_SH_IR;
            `ST_UPD_IR: state_next = tms_s ? `ST_SEL_DR : `ST_IDLE;
            default:    state_next = `ST_RESET;
        endcase
    end

    // Two-flop synchronisers; stage two is read, and tck has a third stage for edge detection
    always @(posedge clk)
    begin
        if (srst)
        begin
            tck_sync_reg  <= 3'h0;
            tms_sync_reg  <= 2'h3;
            tdi_sync_reg  <= 2'h0;
            // Idle level of trst_n, so srst gives no extra test reset
            trst_sync_reg <= 2'h3;
            pin_sync1_reg <= {NPINS{1'b0}};
            pin_sync2_reg <= {NPINS{1'b0}};
        end
        else
        begin
            tck_sync_reg  <= {tck_sync_reg[1:0], tck};
            tms_sync_reg  <= {tms_sync_reg[0], tms};
            tdi_sync_reg  <= {tdi_sync_reg[0], tdi};
            trst_sync_reg <= {trst_sync_reg[0], trst_n};
            pin_sync1_reg <= pin_in;
            pin_sync2_reg <= pin_sync1_reg;
        end
    end

    always @(posedge clk)
    begin
        if (srst || !trst_sync_reg[1])
        begin
            state_reg      <= `ST_RESET;
            ir_shift_reg   <= 4'h0;
            ir_reg         <= `OP_IDCODE;
            bypass_reg     <= 1'b0;
            dr32_reg       <= 32'h0000_0000;
            bsr_shift_reg  <= {NPINS{1'b0}};
            bsr_update_reg <= {NPINS{1'b0}};
            probe_reg      <= {PROBE_W{1'b0}};
            tdo            <= 1'b0;
            tdo_oe         <= 1'b0;
            pin_out        <= {NPINS{1'b0}};
            test_mode      <= 1'b0;
            cfg_data       <= 1'b0;
            cfg_strobe     <= 1'b0;
            cfg_start      <= 1'b0;
        end
        else
        begin
            cfg_strobe <= 1'b0;
            cfg_start  <= 1'b0;
            // Pins follow core unless external test holds them
            test_mode  <= (op == `OP_EXTEST); // see R7
            pin_out    <= (op == `OP_EXTEST) ? bsr_update_reg : core_out; // see R6
            if (tck_rise)
            begin
                state_reg <= state_next;
                case (state_reg)
                    `ST_RESET:
                        ir_reg <= `OP_IDCODE;
                    `ST_CAP_IR:
                        ir_shift_reg <= `IR_CAPTURE;
                    `ST_SH_IR:
                        ir_shift_reg <= {tdi_s, ir_shift_reg[3:1]};
                    `ST_UPD_IR:
                        ir_reg <= ir_shift_reg;
                    `ST_CAP_DR:
                    begin
                        bypass_reg <= 1'b0; // see R3
                        case (op)
                            `OP_IDCODE:   dr32_reg <= `ID_RESET; // see R5
                            `OP_USERCODE: dr32_reg <= user_code; // see R4
                            `OP_EXTEST, `OP_SAMPLE:
                                bsr_shift_reg <= pin_sync2_reg; // see R6
                            `OP_ANALYSER: probe_reg <= probe_in; // see R9
                            default:      bypass_reg <= 1'b0;
                        endcase
                    end
                    `ST_SH_DR:
                    begin
                        case (op)
                            `OP_IDCODE, `OP_USERCODE:
                                dr32_reg <= {tdi_s, dr32_reg[31:1]}; // see R4
                            `OP_EXTEST, `OP_SAMPLE:
                                bsr_shift_reg <= {tdi_s, bsr_shift_reg[NPINS-1:1]};
                            `OP_ANALYSER:
                                probe_reg <= {tdi_s, probe_reg[PROBE_W-1:1]};
                            `OP_CFG_LOAD:
                            begin
                                cfg_data   <= tdi_s; // see R8
                                cfg_strobe <= 1'b1;
                            end
                            default:
                                bypass_reg <= tdi_s; // see R3
                        endcase
                    end
                    `ST_UPD_DR:
                    begin
                        if (op == `OP_EXTEST || op == `OP_SAMPLE)
                            bsr_update_reg <= bsr_shift_reg; // see R6
                        if (op == `OP_CFG_START)
                            cfg_start <= 1'b1; // see R8
                    end
                    default:
                        bypass_reg <= bypass_reg;
                endcase
            end
            // Output changes on the falling edge, as the standard asks
            if (tck_fall)
            begin
                tdo_oe <= shift_dr | shift_ir;
                if (shift_ir)
                    tdo <= ir_shift_reg[0];
                else
                    case (op)
                        `OP_IDCODE, `OP_USERCODE: tdo <= dr32_reg[0];
                        `OP_EXTEST, `OP_SAMPLE:   tdo <= bsr_shift_reg[0];
                        `OP_ANALYSER:             tdo <= probe_reg[0];
                        `OP_CFG_LOAD:             tdo <= 1'b0;
                        default:                  tdo <= bypass_reg; // see R3
                    endcase
            end
        end
    end
endmodule // boundary_scan_test_port

/* File: tb/tap_checker.sv */
`timescale 1ns/1ps
module tap_checker #(parameter NPINS = 8, parameter PROBE_W = 16) (
    input wire             clk,
    input wire             srst,
    input wire             tck,
    input wire             config_busy,
    input wire             tdo,
    input wire             tdo_oe,
    input wire             test_mode,
    input wire             cfg_strobe,
    input wire             cfg_start,
    input wire [NPINS-1:0] core_out,
    input wire [NPINS-1:0] pin_out
);
    reg       tck_q;
    reg [3:0] rise_n;
    reg [3:0] fall_n;
    // Clocks since each tck edge; saturate so idle periods never wrap
    always @(posedge clk)
    begin
        tck_q <= tck;
        rise_n <= srst ? 4'hF : (tck & !tck_q) ? 4'h0 : rise_n + (rise_n != 4'hF);
        fall_n <= srst ? 4'hF : (!tck & tck_q) ? 4'h0 : fall_n + (fall_n != 4'hF);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    reset_clear_a: assert property (disable iff (1'b0)
        srst |=> !tdo && !tdo_oe && !test_mode && !cfg_strobe && !cfg_start && pin_out == 0)
        else $error("outputs not cleared by reset");
    strobe_pulse_a: assert property (cfg_strobe |=> !cfg_strobe)
        else $error("cfg_strobe longer than one clock");
    start_pulse_a: assert property (cfg_start |=> !cfg_start)
        else $error("cfg_start longer than one clock");
    normal_pins_a: assert property (!test_mode && !$past(test_mode) && !$past(srst)
        |-> pin_out == $past(core_out)) else $error("pin_out not core_out");
    busy_blocks_a: assert property (config_busy [*8] |=> !$rose(test_mode))
        else $error("external test entered during configuration");
    tdo_timing_a: assert property ($changed(tdo) && !$past(srst) |-> fall_n <= 4'h8)
        else $error("tdo moved away from a tck fall");
    strobe_timing_a: assert property (cfg_strobe |-> rise_n <= 4'h8)
        else $error("cfg_strobe away from a tck rise");
    oe_timing_a: assert property ($changed(tdo_oe) && !$past(srst) |-> fall_n <= 4'h8)
        else $error("tdo_oe moved away from a tck fall");
    cover property (cfg_strobe);
    cover property (cfg_start);
    cover property ($rose(test_mode));
endmodule // tap_checker

/* File: tb/jtag_ctrl.sv */
`timescale 1ns/1ps
module jtag_ctrl (
    input  wire clk,
    input  wire tdo_line,
    output reg  tck,
    output reg  tms,
    output reg  tdi
);
    initial tck = 1'b0;
    initial tms = 1'b1;
    initial tdi = 1'b0;
    // One 32 ns tck cycle, 16 ns low then 16 ns high; tck rests low between frames
    task step(input t, input d, output o);
    begin
        @(posedge clk) #1;
        tms = t;
        tdi = d;
        repeat (3) @(posedge clk);
        #1 tck = 1'b1;
        repeat (4) @(posedge clk);
        o = tdo_line;
        #1 tck = 1'b0;
        tdi = ~d;
    end
    endtask
    // From Idle through Shift-IR or Shift-DR and back, LSB first
    task shift(input ir, input [31:0] din, input integer n, output [31:0] dout);
        integer i;
        reg     x;
    begin
        dout = 32'h0000_0000;
        step(1'b1, 1'b0, x);
        if (ir)
            step(1'b1, 1'b0, x);
        step(1'b0, 1'b0, x);
        step(1'b0, 1'b0, x);
        for (i = 0; i < n; i = i + 1)
            step(i == n - 1, din[i], dout[i]);
        step(1'b1, 1'b0, x);
        step(1'b0, 1'b0, x);
    end
    endtask
endmodule // jtag_ctrl

/* File: tb/boundary_scan_test_port_tb.sv */
`timescale 1ns/1ps
`include "jtag_tap_defines.vh"
module boundary_scan_test_port_tb;
    reg         clk = 1'b0;
    reg         srst = 1'b1;
    reg         config_busy = 1'b0;
    reg  [31:0] d;
    reg  [7:0]  cfg_bits = 8'h00;
    reg  [7:0]  n_strb = 8'h00;
    reg  [7:0]  n_start = 8'h00;
    reg  [7:0]  s0;
    reg         x;
    integer     mismatches = 0;
    integer     n_checks = 0;
    wire        tck, tms, tdi, tdo, tdo_oe, test_mode, cfg_data, cfg_strobe, cfg_start;
    wire [7:0]  pin_out;
    // TDO floats to its pull-up outside Shift states
    wire        tdo_line = tdo_oe ? tdo : 1'b1;
    boundary_scan_test_port i_dut (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(1'b1), .config_busy(config_busy), .user_code(32'hA5C3_0F96),
        .pin_in(8'h96), .core_out(8'h5A), .probe_in(16'h5AC3), .tdo(tdo), .tdo_oe(tdo_oe),
        .pin_out(pin_out), .test_mode(test_mode), .cfg_data(cfg_data),
        .cfg_strobe(cfg_strobe), .cfg_start(cfg_start));
    jtag_ctrl i_ctrl (.clk(clk), .tdo_line(tdo_line), .tck(tck), .tms(tms), .tdi(tdi));
    initial forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        if (cfg_strobe)
            cfg_bits <= {cfg_data, cfg_bits[7:1]};
        n_strb <= n_strb + cfg_strobe;
        n_start <= n_start + cfg_start;
    end
    task check(input [31:0] seen, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task ir(input [3:0] op);
    begin
        i_ctrl.shift(1'b1, {28'h000_0000, op}, 4, d);
        check(d[3:0], `IR_CAPTURE);
        check({31'h0, tdo_oe}, 32'h0);
    end
    endtask
    task t_bypass(input [3:0] op);
    begin
        ir(op);
        i_ctrl.shift(1'b0, 32'h0000_00B5, 8, d);
        check(d[7:0], 8'h6A);
        check(pin_out, 8'h5A);
    end
    endtask
    task t_reg(input [3:0] op, input integer n, input [31:0] exp);
    begin
        ir(op);
        i_ctrl.shift(1'b0, 32'h0000_0000, n, d);
        check(d, exp);
    end
    endtask
    task t_scan;
    begin
        ir(`OP_SAMPLE);
        i_ctrl.shift(1'b0, 32'h0000_003C, 8, d);
        check(d[7:0], 8'h96);
        check(pin_out, 8'h5A);
        ir(`OP_EXTEST);
        check(pin_out, 8'h3C);
        check({31'h0, test_mode}, 32'h1);
        i_ctrl.shift(1'b0, 32'h0000_00C1, 8, d);
        check(d[7:0], 8'h96);
        check(pin_out, 8'hC1);
        ir(`OP_BYPASS);
        check({31'h0, test_mode}, 32'h0);
    end
    endtask
    task t_cfg;
    begin
        ir(`OP_CFG_LOAD);
        s0 = n_strb;
        i_ctrl.shift(1'b0, 32'h0000_00C5, 8, d);
        check(n_strb - s0, 8'h08);
        check(cfg_bits, 8'hC5);
        ir(`OP_CFG_START);
        s0 = n_start;
        i_ctrl.shift(1'b0, 32'h0000_0000, 1, d);
        check(n_start - s0, 8'h01);
    end
    endtask
    task stop_test;
    begin
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    // A full run is near 10 us; a hang is cut well beyond that
    initial
    begin
        #100000;
        mismatches = mismatches + 1;
        stop_test;
    end
    initial
    begin
        repeat (2) @(posedge clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge clk);
        i_ctrl.step(1'b0, 1'b0, x);
        i_ctrl.shift(1'b0, 32'h0000_0000, 32, d);
        check(d, `ID_RESET);
        t_reg(`OP_USERCODE, 32, 32'hA5C3_0F96);
        t_reg(`OP_ANALYSER, 16, 32'h0000_5AC3);
        t_bypass(`OP_BYPASS);
        t_bypass(4'h7);
        config_busy = 1'b1;
        t_bypass(`OP_SAMPLE);
        t_bypass(`OP_EXTEST);
        check({31'h0, test_mode}, 32'h0);
        config_busy = 1'b0;
        t_scan;
        t_cfg;
        stop_test;
    end
endmodule // boundary_scan_test_port_tb
bind boundary_scan_test_port tap_checker #(.NPINS(NPINS), .PROBE_W(PROBE_W)) i_chk (
    .clk(clk), .srst(srst), .tck(tck), .config_busy(config_busy), .tdo(tdo),
    .tdo_oe(tdo_oe), .test_mode(test_mode), .cfg_strobe(cfg_strobe),
    .cfg_start(cfg_start), .core_out(core_out), .pin_out(pin_out));
